/* rtl/iwlc_ctrl.sv */
// interrupt controller with watchdog and low-voltage flag path
// assumes the core pulses one instruction strobe per cycle, synchronous inputs
`timescale 1ns/1ps
`include "iwlc_defines.svh"
`default_nettype none
module iwlc_ctrl #(
   parameter int CNT_W = 18,
   parameter int TICKS_P0 = `IWLC_WDT_P0_US * 1000 / `IWLC_TICK_NS,
   parameter int TICKS_P1 = `IWLC_WDT_P1_US * 1000 / `IWLC_TICK_NS,
   parameter int TICKS_P2 = `IWLC_WDT_P2_US * 1000 / `IWLC_TICK_NS,
   parameter int TICKS_P3 = `IWLC_WDT_P3_US * 1000 / `IWLC_TICK_NS,
   parameter int TICK_DIV = `IWLC_TICK_NS / `IWLC_CLK_NS
) (
   input wire logic sys_clk,
   input wire logic nrst,
   // instruction strobes from the sequencer
   input wire logic swIntInstr,
   input wire logic returnIrqInstr,
   input wire logic enableIrqInstr,
   input wire logic disableIrqInstr,
   input wire logic wdogClearInstr,
   // flag and enable register access
   input wire logic flagWrite,
   input wire logic [7:0] flagWrData,
   input wire logic enableWrite,
   input wire logic [7:0] enableWrData,
   // event sources
   input wire logic [7:0] timer0Count,
   input wire logic [7:0] timer1Count,
   input wire logic lowvoltCompare,
   // configuration options and control bits
   input wire logic wdogCfgEnable,
   input wire logic wdogCfgIrqMode,
   input wire logic [1:0] wdogCfgPeriod,
   input wire logic wdogRunEnable,
   input wire logic prescalerToWdog,
   input wire logic [2:0] prescalerRatioSel,
   input wire logic lowvoltEnable,
   // outputs to the core
   output logic vectorLoad,
   output logic [10:0] vectorAddr,
   output logic globalIrqEnable,
   output logic [7:0] irqFlagRead,
   output logic [7:0] irqEnableReg,
   output logic irqPending,
   output logic wdogResetReq,
   output logic timeoutStatusFlag,
   output logic lowvoltState
);
   typedef struct packed {
      iwlc_pkg::iwlc_state_t fsm;
      logic global_irq_enable;
      logic [7:0] flags;
      logic [7:0] en;
      logic [7:0] t0Prev;
      logic [7:0] t1Prev;
      logic lvPrev;
      logic lvState;
      logic toFlag;
      logic vecLoad;
      logic [10:0] vec;
      logic wdRst;
      logic [15:0] div;
      logic tick;
   } iwlc_st_t;
   iwlc_st_t st, next_st;
   logic wdExpire;
   logic [7:0] events;
   logic hwTake;

   initial begin
      if (TICK_DIV < 1) $error("watchdog tick divider must be at least one");
      if (TICKS_P3 >= (1 << CNT_W)) $error("watchdog counter too narrow");
   end

   // flag bit reads back set only where enabled
   function automatic logic [7:0] masked(input logic [7:0] f, input logic [7:0] e);
      masked = f & e;
   endfunction

   iwlc_wdog #(
      .CNT_W(CNT_W)
   ) u_wdog (
      .sysClk(sys_clk),
      .nRst(nrst),
      .tickEn(st.tick),
      .runEn(wdogCfgEnable && wdogRunEnable),
      .clearCmd(wdogClearInstr && prescalerToWdog),
      .psAttach(prescalerToWdog),
      .irqMode(wdogCfgIrqMode),
      .psSel(prescalerRatioSel),
      .periodSel(wdogCfgPeriod),
      .limP0(CNT_W'(TICKS_P0)),
      .limP1(CNT_W'(TICKS_P1)),
      .limP2(CNT_W'(TICKS_P2)),
      .limP3(CNT_W'(TICKS_P3)),
      .expire(wdExpire)
   );

   // event detection: wraps of the timers, expiry and falling detector
   always_comb begin
      events = 8'h00;
      events[`IWLC_BIT_T0] = (st.t0Prev == 8'hFF) && (timer0Count == 8'h00);
      events[`IWLC_BIT_T1] = (st.t1Prev == 8'hFF) && (timer1Count == 8'h00);
      events[`IWLC_BIT_WDOG] = wdExpire && wdogCfgIrqMode;
      events[`IWLC_BIT_LVD] = st.lvPrev && !st.lvState;
      // one shared request, no priority between sources
      hwTake = st.global_irq_enable && (|masked(st.flags, st.en)) && (st.fsm == iwlc_pkg::IWLC_RUN);
   end

   always_comb begin
      next_st = st;
      next_st.vecLoad = 1'b0;
      next_st.wdRst = 1'b0;
      next_st.t0Prev = timer0Count;
      next_st.t1Prev = timer1Count;
      next_st.lvPrev = st.lvState;
      // detector output low while enabled and supply below threshold
      next_st.lvState = lowvoltEnable ? lowvoltCompare : 1'b1;
      // free tick divider for the watchdog time base
      if (st.div >= 16'(TICK_DIV - 1)) begin
         next_st.div = 16'h0000;
         next_st.tick = 1'b1;
      end else begin
         next_st.div = st.div + 16'h0001;
         next_st.tick = 1'b0;
      end
      if (enableWrite) begin
         next_st.en = enableWrData;
      end
      // set beats clear so a simultaneous event is not lost
      if (flagWrite) begin
         next_st.flags = st.flags & flagWrData;
      end
      next_st.flags = next_st.flags | events;
      // global enable: enable or return wins over disable when strobes collide
      if (enableIrqInstr || returnIrqInstr) begin
         next_st.global_irq_enable = 1'b1;
      end else if (disableIrqInstr) begin
         next_st.global_irq_enable = 1'b0;
      end
      if (wdogClearInstr && prescalerToWdog) begin
         next_st.toFlag = 1'b1;
      end
      if (wdExpire) begin
         next_st.toFlag = 1'b0;
         next_st.wdRst = !wdogCfgIrqMode;
      end
      case (st.fsm)
         iwlc_pkg::IWLC_RUN: begin
            if (swIntInstr) begin
               next_st.vecLoad = 1'b1;
               next_st.vec = `IWLC_SW_VECTOR;
               next_st.global_irq_enable = 1'b0;
               next_st.fsm = iwlc_pkg::IWLC_VEC;
            end else if (hwTake) begin
               next_st.vecLoad = 1'b1;
               next_st.vec = `IWLC_HW_VECTOR;
               next_st.global_irq_enable = 1'b0;
               next_st.fsm = iwlc_pkg::IWLC_VEC;
            end
         end
         iwlc_pkg::IWLC_VEC: begin
            next_st.fsm = iwlc_pkg::IWLC_SVC;
         end
         iwlc_pkg::IWLC_SVC: begin
            // nesting allowed once firmware re-enables inside the routine
            if (returnIrqInstr) begin
               next_st.fsm = iwlc_pkg::IWLC_RUN;
            end else if (swIntInstr || (st.global_irq_enable && |masked(st.flags, st.en))) begin
               next_st.vecLoad = 1'b1;
               next_st.vec = swIntInstr ? `IWLC_SW_VECTOR : `IWLC_HW_VECTOR;
               next_st.global_irq_enable = 1'b0;
               next_st.fsm = iwlc_pkg::IWLC_VEC;
            end
         end
         default: begin
            next_st.fsm = iwlc_pkg::IWLC_RUN;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
         st.flags <= `IWLC_FLAG_RST;
         st.toFlag <= `IWLC_TO_RST;
         st.lvState <= 1'b1;
         st.lvPrev <= 1'b1;
         st.fsm <= iwlc_pkg::IWLC_RUN;
      end else begin
         st <= next_st;
      end
   end

   assign vectorLoad = st.vecLoad;
   assign vectorAddr = st.vec;
   assign globalIrqEnable = st.global_irq_enable;
   assign irqFlagRead = masked(st.flags, st.en);
   assign irqEnableReg = st.en;
   assign irqPending = st.global_irq_enable && (|masked(st.flags, st.en));
   assign wdogResetReq = st.wdRst;
   assign timeoutStatusFlag = st.toFlag;
   assign lowvoltState = st.lvState;
endmodule
`default_nettype wire

/* shared/iwlc_defines.svh */
// constants of the interrupt, watchdog and low-voltage block
// assumes a 40 MHz instruction clock and a slow watchdog tick enable
// How it works
// - soft interrupt vectors to 0x001, clears global enable
// - enabled pending flag with global enable vectors 0x008
// - each source sets sticky flag until written zero
// - flag reads as set only when enabled
// - return instruction sets global enable, resumes
// - enable and disable instructions drive global enable
// - timer0 wrap 0xFF to 0x00 sets flag
// - timer1 count 0xFF to 0x00 sets flag
// - watchdog counting gated by run enable bit
// - timeout resets or interrupts, clears timeout status
// - two option bits pick base timeout period
// - prescaler attach lengthens timeout by selected ratio
// - clear instruction, with prescaler attached, clears counter, prescaler, sets status
// - interrupt mode expiry sets watchdog flag bit 6
// - watchdog runs from a free tick divided from the system clock
// - low supply with detector enabled drives state low
// - live detector state readable by software
// - timer0 flag and enable at bit 0
// - timer1 flag and enable at bit 3
// - low supply sets low-voltage flag
`ifndef IWLC_DEFINES_SVH
`define IWLC_DEFINES_SVH
`define IWLC_SW_VECTOR 11'h001
`define IWLC_HW_VECTOR 11'h008
`define IWLC_BIT_T0 0
`define IWLC_BIT_T1 3
`define IWLC_BIT_WDOG 6
`define IWLC_BIT_LVD 7
`define IWLC_FLAG_RST 8'h00
`define IWLC_TO_RST 1'b1
// base periods in microseconds, counted in watchdog ticks of 1 us
`define IWLC_WDT_P0_US 3500
`define IWLC_WDT_P1_US 15000
`define IWLC_WDT_P2_US 60000
`define IWLC_WDT_P3_US 250000
`define IWLC_TICK_NS 1000
`define IWLC_CLK_NS 25
`endif

/* shared/iwlc_pkg.sv */
// types of the interrupt, watchdog and low-voltage block
// assumes the defines header is compiled alongside
package iwlc_pkg;
   typedef enum logic [1:0] {
      IWLC_RUN = 2'b00,
      IWLC_VEC = 2'b01,
      IWLC_SVC = 2'b10
   } iwlc_state_t;
endpackage

/* rtl/iwlc_wdog.sv */
// watchdog counter with optional prescaler stage
// assumes tickEn is a one-cycle pulse from the free tick divider of the system clock
`timescale 1ns/1ps
`include "iwlc_defines.svh"
`default_nettype none
module iwlc_wdog #(
   parameter int CNT_W = 18
) (
   input wire logic sysClk,
   input wire logic nRst,
   input wire logic tickEn,
   input wire logic runEn,
   input wire logic clearCmd,
   input wire logic psAttach,
   input wire logic irqMode,
   input wire logic [2:0] psSel,
   input wire logic [1:0] periodSel,
   input wire logic [CNT_W-1:0] limP0,
   input wire logic [CNT_W-1:0] limP1,
   input wire logic [CNT_W-1:0] limP2,
   input wire logic [CNT_W-1:0] limP3,
   output logic expire
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic [7:0] ps;
      logic exp;
   } iwlc_wd_t;
   iwlc_wd_t st, next_st;
   logic [CNT_W-1:0] lim;
   logic [8:0] psMax;

   initial begin
      if (CNT_W < 18) $error("watchdog counter too narrow for 250 ms");
   end

   // prescaler ratio: reset mode 1:1..1:128, interrupt mode 1:2..1:256
   always_comb begin
      case (periodSel)
         2'd0: lim = limP0;
         2'd1: lim = limP1;
         2'd2: lim = limP2;
         default: lim = limP3;
      endcase
      // shift amount widened so 1:256 does not wrap back to 1:1
      psMax = psAttach ? (9'h001 << ({1'b0, psSel} + {3'b000, irqMode})) : 9'h001;
   end

   // one base period elapses per wrap; prescaler counts wraps
   always_comb begin
      next_st = st;
      next_st.exp = 1'b0;
      if (clearCmd) begin
         next_st.cnt = '0;
         next_st.ps = 8'h00;
      end else if (tickEn && runEn) begin
         if (st.cnt >= lim - 1'b1) begin
            next_st.cnt = '0;
            if ({1'b0, st.ps} >= psMax - 9'h001) begin
               next_st.ps = 8'h00;
               next_st.exp = 1'b1;
            end else begin
               next_st.ps = st.ps + 8'h01;
            end
         end else begin
            next_st.cnt = st.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge sysClk or negedge nRst) begin
      if (!nRst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign expire = st.exp;
endmodule
`default_nettype wire

/* sim/iwlc_ctrl_monitor.sv */
// checker for the interrupt controller ports
// assumes one clock domain and the async active-low reset
`timescale 1ns/1ps
`default_nettype none
module iwlc_ctrl_monitor (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic swIntInstr,
   input wire logic returnIrqInstr,
   input wire logic enableIrqInstr,
   input wire logic disableIrqInstr,
   input wire logic flagWrite,
   input wire logic enableWrite,
   input wire logic lowvoltCompare,
   input wire logic lowvoltEnable,
   input wire logic vectorLoad,
   input wire logic [10:0] vectorAddr,
   input wire logic globalIrqEnable,
   input wire logic [7:0] irqFlagRead,
   input wire logic [7:0] irqEnableReg,
   input wire logic irqPending,
   input wire logic wdogResetReq,
   input wire logic timeoutStatusFlag,
   input wire logic lowvoltState
);
   default clocking mon_cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   sw_vector_a: assert property (swIntInstr && !vectorLoad && !irqPending
      |=> vectorLoad && vectorAddr == 11'h001) else $error("soft vector missing");
   hw_vector_a: assert property (irqPending && globalIrqEnable && !vectorLoad && !swIntInstr
      |=> vectorLoad && vectorAddr == 11'h008) else $error("hard vector missing");
   vector_gie_a: assert property (vectorLoad |-> !globalIrqEnable)
      else $error("global enable kept on vector");
   gie_set_a: assert property (returnIrqInstr || enableIrqInstr
      |=> globalIrqEnable || vectorLoad) else $error("global enable not set");
   gie_clear_a: assert property (disableIrqInstr && !enableIrqInstr && !returnIrqInstr
      |=> !globalIrqEnable) else $error("global enable not cleared");
   gie_cause_a: assert property ($rose(globalIrqEnable)
      |-> $past(enableIrqInstr || returnIrqInstr)) else $error("global enable rose alone");
   flag_mask_a: assert property ((irqFlagRead & ~irqEnableReg) == 8'h00)
      else $error("masked flag visible");
   flag_sticky_a: assert property (!$past(flagWrite) && !$past(enableWrite)
      |-> ($past(irqFlagRead) & ~irqFlagRead) == 8'h00) else $error("flag dropped");
   to_clear_a: assert property (wdogResetReq |-> ##[0:1] !timeoutStatusFlag)
      else $error("timeout status kept");
   lv_low_a: assert property (lowvoltEnable && !lowvoltCompare ##1
      lowvoltEnable && !lowvoltCompare |-> !lowvoltState) else $error("detector state high");
endmodule
bind iwlc_ctrl iwlc_ctrl_monitor iwlc_ctrl_monitor_i (.sys_clk, .nrst, .swIntInstr,
   .returnIrqInstr, .enableIrqInstr, .disableIrqInstr, .flagWrite, .enableWrite,
   .lowvoltCompare, .lowvoltEnable, .vectorLoad, .vectorAddr, .globalIrqEnable,
   .irqFlagRead, .irqEnableReg, .irqPending, .wdogResetReq, .timeoutStatusFlag,
   .lowvoltState);
`default_nettype wire

/* sim/iwlc_core_model.sv */
// stand-in for the sequencer running a service routine
// assumes vectorLoad is a one-cycle pulse; drives at the falling edge
`timescale 1ns/1ps
`default_nettype none
module iwlc_core_model #(
   parameter int ISR_LEN = 5
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic vectorLoad,
   output logic returnIrqInstr
);
   int left;
   // routine ends with a return, never with an enable just before it
   always @(negedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         left = 0;
         returnIrqInstr = 1'b0;
      end else begin
         returnIrqInstr = (left == 1);
         if (vectorLoad === 1'b1) left = ISR_LEN;
         else if (left > 0) left = left - 1;
      end
   end
endmodule
`default_nettype wire

/* sim/iwlc_ctrl_tb_top.sv */
// self-checking bench for the interrupt controller
// assumes shortened watchdog counts; core model answers vectors
`timescale 1ns/1ps
`default_nettype none
module iwlc_ctrl_tb_top;
   logic sys_clk = 1'b0;
   logic nrst, swIntInstr, returnIrqInstr, enableIrqInstr, disableIrqInstr, wdogClearInstr;
   logic flagWrite, enableWrite, lowvoltCompare, wdogCfgEnable, wdogCfgIrqMode;
   logic wdogRunEnable, prescalerToWdog, lowvoltEnable, vectorLoad, globalIrqEnable;
   logic irqPending, wdogResetReq, timeoutStatusFlag, lowvoltState;
   logic [7:0] flagWrData, enableWrData, timer0Count, timer1Count, irqFlagRead, irqEnableReg;
   logic [1:0] wdogCfgPeriod;
   logic [2:0] prescalerRatioSel;
   logic [10:0] vectorAddr;
   int n_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   // short counts keep the watchdog runs to tens of cycles
   iwlc_ctrl #(.TICKS_P0(4), .TICKS_P1(8), .TICKS_P2(16), .TICKS_P3(32), .TICK_DIV(2))
   iwlc_ctrl_i (.sys_clk, .nrst, .swIntInstr, .returnIrqInstr, .enableIrqInstr,
      .disableIrqInstr, .wdogClearInstr, .flagWrite, .flagWrData, .enableWrite,
      .enableWrData, .timer0Count, .timer1Count, .lowvoltCompare, .wdogCfgEnable,
      .wdogCfgIrqMode, .wdogCfgPeriod, .wdogRunEnable, .prescalerToWdog,
      .prescalerRatioSel, .lowvoltEnable, .vectorLoad, .vectorAddr, .globalIrqEnable,
      .irqFlagRead, .irqEnableReg, .irqPending, .wdogResetReq, .timeoutStatusFlag,
      .lowvoltState);
   iwlc_core_model iwlc_core_model_i (.sys_clk, .nrst, .vectorLoad, .returnIrqInstr);
   always #12.5 sys_clk = ~sys_clk;
   // hang guard, well above the few hundred cycles the tests need
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic wait_vec(input logic [10:0] a);
      int i;
      for (i = 0; i < 4 && vectorLoad !== 1'b1; i++) tick(1);
      chk(11'(vectorLoad), 11'h001);
      chk(vectorAddr, a);
   endtask
   // soft interrupt ignores the global enable; then disable and enable
   task automatic t_gie();
      chk(11'(timeoutStatusFlag), 11'h001);
      swIntInstr = 1'b1;
      tick(1);
      swIntInstr = 1'b0;
      wait_vec(11'h001);
      chk(11'(globalIrqEnable), 11'h000);
      tick(7);
      chk(11'(globalIrqEnable), 11'h001);
      disableIrqInstr = 1'b1;
      tick(1);
      disableIrqInstr = 1'b0;
      chk(11'(globalIrqEnable), 11'h000);
      enableIrqInstr = 1'b1;
      tick(1);
      enableIrqInstr = 1'b0;
      chk(11'(globalIrqEnable), 11'h001);
      $display("global enable test done");
   endtask
   // event while masked stays pending, taken once its enable is written
   task automatic t_src(input int b);
      logic [7:0] m;
      m = 8'h01 << b;
      case (b)
         0: timer0Count = 8'hFF;
         3: timer1Count = 8'hFF;
         default: begin
            lowvoltCompare = 1'b1;
            lowvoltEnable = 1'b1;
         end
      endcase
      tick(1);
      if (b == 7) chk(11'(lowvoltState), 11'h001);
      timer0Count = 8'h00;
      timer1Count = 8'h00;
      lowvoltCompare = 1'b0;
      // let the detector state settle before trusting it
      tick(2);
      chk(11'(irqFlagRead), 11'h000);
      if (b == 7) chk(11'(lowvoltState), 11'h000);
      enableWrite = 1'b1;
      enableWrData = m;
      tick(1);
      enableWrite = 1'b0;
      wait_vec(11'h008);
      chk(11'(globalIrqEnable), 11'h000);
      chk(11'(irqFlagRead), 11'(m));
      flagWrite = 1'b1;
      flagWrData = ~m;
      tick(1);
      flagWrite = 1'b0;
      lowvoltEnable = 1'b0;
      tick(1);
      chk(11'(irqFlagRead), 11'h000);
      tick(6);
      chk(11'(globalIrqEnable), 11'h001);
      $display("source test done");
   endtask
   // expiry in interrupt mode, clear, run gating, then reset mode
   task automatic t_wdog();
      int i;
      enableWrite = 1'b1;
      enableWrData = 8'h40;
      wdogCfgIrqMode = 1'b1;
      wdogRunEnable = 1'b1;
      wdogCfgEnable = 1'b1;
      tick(1);
      enableWrite = 1'b0;
      for (i = 0; i < 100 && vectorLoad !== 1'b1; i++) tick(1);
      wdogRunEnable = 1'b0;
      chk(11'(irqFlagRead), 11'h040);
      chk(11'(timeoutStatusFlag), 11'h000);
      prescalerToWdog = 1'b1;
      wdogClearInstr = 1'b1;
      flagWrite = 1'b1;
      flagWrData = 8'hBF;
      tick(1);
      wdogClearInstr = 1'b0;
      flagWrite = 1'b0;
      tick(150);
      chk(11'(timeoutStatusFlag), 11'h001);
      chk(11'(irqFlagRead), 11'h000);
      // reset mode at 1:4: 4 ticks x 4 wraps x 2 cycles, plus two register stages
      wdogCfgIrqMode = 1'b0;
      prescalerRatioSel = 3'h2;
      wdogRunEnable = 1'b1;
      for (i = 0; i < 300 && wdogResetReq !== 1'b1; i++) tick(1);
      chk(11'(wdogResetReq), 11'h001);
      chk(11'(timeoutStatusFlag), 11'h000);
      chk(11'(i >= 31 && i <= 34), 11'h001);
      wdogCfgEnable = 1'b0;
      $display("watchdog test done");
   endtask
   // firmware re-enables first in the routine, so a hardware event nests
   task automatic t_nest();
      enableWrite = 1'b1;
      enableWrData = 8'h01;
      timer0Count = 8'hFF;
      swIntInstr = 1'b1;
      tick(1);
      enableWrite = 1'b0;
      swIntInstr = 1'b0;
      timer0Count = 8'h00;
      enableIrqInstr = 1'b1;
      wait_vec(11'h001);
      tick(1);
      enableIrqInstr = 1'b0;
      chk(11'(globalIrqEnable), 11'h001);
      wait_vec(11'h008);
      flagWrite = 1'b1;
      flagWrData = 8'hFE;
      tick(1);
      flagWrite = 1'b0;
      tick(7);
      chk(11'(globalIrqEnable), 11'h001);
      $display("nesting test done");
   endtask
   initial begin
      {nrst, swIntInstr, enableIrqInstr, disableIrqInstr, wdogClearInstr} = '0;
      {flagWrite, enableWrite, lowvoltCompare, wdogCfgEnable, wdogCfgIrqMode} = '0;
      {wdogRunEnable, prescalerToWdog, lowvoltEnable} = '0;
      {flagWrData, enableWrData, timer0Count, timer1Count} = '0;
      wdogCfgPeriod = 2'h0;
      prescalerRatioSel = 3'h0;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk) nrst = 1'b1;
      t_gie();
      t_src(0);
      t_src(3);
      t_src(7);
      t_wdog();
      t_nest();
      end_sim();
   end
endmodule
`default_nettype wire
